// ---- hw/llpe_pkg.sv ----
// shared constants and carriers for the laser line profile extractor
package llpe_pkg;

  localparam int PIX_W  = 16;
  localparam int FRAC_W = 4;
  localparam int MODE_W = 2;
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LOWER  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CEIL   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SPLIT  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_COMB   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

  // field positions
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_RAW16_BIT = 2;
  localparam int CTRL_COMB_BIT  = 3;
  localparam int CTRL_FRAC_LSB  = 4;
  localparam int LOWER_SEC_LSB  = 16;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_FCNT_LSB  = 16;

  // reset values
  localparam logic [31:0]      CTRL_RST  = 32'h0000_0000;
  localparam logic [PIX_W-1:0] LOWER_RST = 16'h0000;
  localparam logic [PIX_W-1:0] CEIL_RST  = 16'hFFFF;
  localparam logic [PIX_W-1:0] SPLIT_RST = 16'h0000;
  localparam logic [PIX_W-1:0] COMB_RST  = 16'h0001;

  // output path selections
  localparam logic [MODE_W-1:0] MODE_PROC = 2'h0;
  localparam logic [MODE_W-1:0] MODE_RAW  = 2'h1;
  localparam logic [MODE_W-1:0] MODE_PROF = 2'h2;

  typedef struct packed {
    logic             valid;
    logic             sof;
    logic             eol;
    logic             eof;
    logic [PIX_W-1:0] data;
  } llpe_pix_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } llpe_chunk_t;

  typedef struct packed {
    logic [PIX_W-1:0] run_start;
    logic [PIX_W-1:0] run_len;
    logic [PIX_W-1:0] best_start;
    logic [PIX_W-1:0] best_len;
  } llpe_col_t;

endpackage : llpe_pkg

// ---- hw/llpe_col_unit.sv ----
// per-column cluster tracker step and fixed-point centre of the best cluster
`timescale 1ns/10ps
module llpe_col_unit (
  // pixel and its place
  input  wire logic [15:0]        i_pix,
  input  wire logic [15:0]        i_row,
  input  wire logic               i_first_row,
  input  wire logic [3:0]         i_frac,
  // column state
  input  wire llpe_pkg::llpe_col_t i_st,
  output llpe_pkg::llpe_col_t      o_st,
  output logic [15:0]              o_result
);

  llpe_pkg::llpe_col_t st;
  logic [16:0]         sum;
  logic [31:0]         wide;

  always_comb begin
    st   = i_first_row ? '0 : i_st;
    o_st = st;
    if (i_pix != 16'h0000) begin
      o_st.run_len = st.run_len + 16'h0001;
      if (st.run_len == 16'h0000) begin
        o_st.run_start = i_row;
      end
    end else begin
      if (st.run_len > st.best_len) begin
        o_st.best_start = st.run_start;
        o_st.best_len   = st.run_len;
      end
      o_st.run_len = 16'h0000;
    end
  end

  always_comb begin
    sum  = {1'b0, o_st.best_start} + {1'b0, o_st.best_start} + {1'b0, o_st.best_len} - 17'h00001;
    wide = ({15'h0000, sum} << i_frac) >> 1;
    // scaled by two to the d
    o_result = (o_st.best_len == 16'h0000) ? 16'h0000 : wide[15:0];
  end

endmodule : llpe_col_unit

// ---- hw/llpe_top.sv ----
// laser line profile extractor: clamps, column tracking, profile output, AHB-Lite registers
// Contract
// - one 16-bit result per column of every frame that ends while emission is idle
// - pixels below the active lower clamp become zero
// - pixels above the saturation ceiling become the ceiling
// - clusters are maximal runs of adjacent non-zero pixels
// - the largest cluster's centre is the column result
// - result is unsigned fixed point, position times two to the d
// - row positions count from the top of the region of interest
// - mode 0 feeds processed pixels, full frame, results in chunk field
// - mode 1 feeds raw pixels, full frame, results in chunk field
// - mode 2 outputs only the profile, one line of words
// - in mode 2 the colour coding picks processed or raw input
// - combiner packs a set number of profile lines per frame
// - combiner never drops a line between packed frames
// - first lower clamp below split column, second lower clamp beyond
// - chunk words go low byte first, then high byte
`timescale 1ns/10ps
module llpe_top #(
  parameter int MAX_COLS = 4096
) (
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_arst_n,
  // AHB-Lite slave
  input  wire logic                i_hsel,
  input  wire logic [31:0]         i_haddr,
  input  wire logic [1:0]          i_htrans,
  input  wire logic                i_hwrite,
  input  wire logic [2:0]          i_hsize,
  input  wire logic [31:0]         i_hwdata,
  input  wire logic                i_hready,
  output logic [31:0]              o_hrdata,
  output logic                     o_hreadyout,
  output logic                     o_hresp,
  // pixel sources
  input  wire llpe_pkg::llpe_pix_t i_proc_pix,
  input  wire llpe_pkg::llpe_pix_t i_raw_pix,
  // outputs
  output llpe_pkg::llpe_pix_t      o_vid,
  output llpe_pkg::llpe_chunk_t    o_chunk
);

  localparam int COL_W = (MAX_COLS > 2) ? $clog2(MAX_COLS) : 1;

  if (MAX_COLS < 2 || MAX_COLS > 65536) begin : g_chk
    $error("MAX_COLS must lie in 2..65536");
  end

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_VID   = 3'b010,
    ST_CHUNK = 3'b100
  } llpe_state_t;

  // registers
  logic [31:0]        ctrl_ff;
  logic [15:0]        lo_first_ff;
  logic [15:0]        lo_second_ff;
  logic [15:0]        ceil_ff;
  logic [15:0]        split_ff;
  logic [15:0]        comb_lines_ff;
  logic [15:0]        frame_cnt_ff;
  logic               wr_pend_ff;
  logic [7:0]         wr_addr_ff;
  logic [31:0]        hrdata_ff;
  logic [31:0]        rd_mux;
  logic               addr_ok;
  logic [1:0]         mode;
  logic [3:0]         frac;
  logic               busy;

  // input stage
  llpe_pkg::llpe_pix_t src;
  logic [15:0]        in_col;
  logic [15:0]        in_row;
  logic [15:0]        lower;
  logic [15:0]        clamped;
  logic [15:0]        col_cnt_ff;
  logic [15:0]        row_cnt_ff;
  llpe_pkg::llpe_pix_t s0_ff;
  logic [15:0]        s0_col_ff;
  logic [15:0]        s0_row_ff;

  // column tracking and emission
  llpe_pkg::llpe_col_t col_mem [MAX_COLS];
  llpe_pkg::llpe_col_t upd_st;
  llpe_pkg::llpe_col_t fin_st;
  logic [15:0]        fin_result;
  logic               frame_done;
  llpe_state_t        state_ff;
  logic [15:0]        width_ff;
  logic [15:0]        em_idx_ff;
  logic               hi_ff;
  logic               em_last;
  logic [15:0]        comb_cnt_ff;
  logic               comb_last;
  llpe_pkg::llpe_pix_t vid_ff;
  llpe_pkg::llpe_chunk_t chunk_ff;

  assign mode = ctrl_ff[llpe_pkg::CTRL_MODE_LSB +: llpe_pkg::MODE_W];
  assign frac = ctrl_ff[llpe_pkg::CTRL_FRAC_LSB +: llpe_pkg::FRAC_W];
  assign busy = (state_ff != ST_IDLE);

  // ---------------- AHB-Lite slave ----------------
  assign addr_ok = i_hsel & i_hready & i_htrans[1];

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_haddr[7:0])
      llpe_pkg::OFS_CTRL:   rd_mux = ctrl_ff;
      llpe_pkg::OFS_LOWER:  rd_mux = {lo_second_ff, lo_first_ff};
      llpe_pkg::OFS_CEIL:   rd_mux = {16'h0000, ceil_ff};
      llpe_pkg::OFS_SPLIT:  rd_mux = {16'h0000, split_ff};
      llpe_pkg::OFS_COMB:   rd_mux = {16'h0000, comb_lines_ff};
      llpe_pkg::OFS_STATUS: rd_mux = {frame_cnt_ff, 15'h0000, busy};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff  <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= addr_ok & i_hwrite;
      if (addr_ok) begin
        wr_addr_ff <= i_haddr[7:0];
        hrdata_ff  <= i_hwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // write lands at the end of the data phase; unmapped writes are dropped
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_ff       <= llpe_pkg::CTRL_RST;
      lo_first_ff   <= llpe_pkg::LOWER_RST;
      lo_second_ff  <= llpe_pkg::LOWER_RST;
      ceil_ff       <= llpe_pkg::CEIL_RST;
      split_ff      <= llpe_pkg::SPLIT_RST;
      comb_lines_ff <= llpe_pkg::COMB_RST;
    end else if (wr_pend_ff) begin
      case (wr_addr_ff)
        llpe_pkg::OFS_CTRL:  ctrl_ff <= {24'h000000, i_hwdata[7:0]};
        llpe_pkg::OFS_LOWER: begin
          lo_first_ff  <= i_hwdata[15:0];
          lo_second_ff <= i_hwdata[llpe_pkg::LOWER_SEC_LSB +: 16];
        end
        llpe_pkg::OFS_CEIL:  ceil_ff       <= i_hwdata[15:0];
        llpe_pkg::OFS_SPLIT: split_ff      <= i_hwdata[15:0];
        llpe_pkg::OFS_COMB:  comb_lines_ff <= i_hwdata[15:0];
        default: ;
      endcase
    end
  end

  assign o_hrdata    = hrdata_ff;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // ---------------- source select and clamps ----------------
  always_comb begin
    src = i_proc_pix;
    // raw pixels in mode 1 or mode 2 with raw coding
    if (mode == llpe_pkg::MODE_RAW ||
        (mode == llpe_pkg::MODE_PROF && ctrl_ff[llpe_pkg::CTRL_RAW16_BIT])) begin
      src = i_raw_pix;
    end
  end

  // rows restart at the region top
  assign in_col = src.sof ? 16'h0000 : col_cnt_ff;
  assign in_row = src.sof ? 16'h0000 : row_cnt_ff;

  always_comb begin
    lower   = (in_col < split_ff) ? lo_first_ff : lo_second_ff;
    clamped = src.data;
    if (src.data < lower) begin
      clamped = 16'h0000;
    end else if (src.data > ceil_ff) begin
      clamped = ceil_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      col_cnt_ff <= 16'h0000;
      row_cnt_ff <= 16'h0000;
    end else if (src.valid) begin
      col_cnt_ff <= src.eol ? 16'h0000 : in_col + 16'h0001;
      row_cnt_ff <= src.eol ? in_row + 16'h0001 : in_row;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s0_ff     <= '0;
      s0_col_ff <= 16'h0000;
      s0_row_ff <= 16'h0000;
    end else begin
      s0_ff      <= src;
      s0_ff.data <= clamped;
      s0_col_ff  <= in_col;
      s0_row_ff  <= in_row;
    end
  end

  // ---------------- per-column tracking ----------------
  // one tracker step per pixel
  llpe_col_unit u_upd (
    .i_pix       (s0_ff.data),
    .i_row       (s0_row_ff),
    .i_first_row (s0_row_ff == 16'h0000),
    .i_frac      (frac),
    .i_st        (col_mem[s0_col_ff[COL_W-1:0]]),
    .o_st        (upd_st),
    .o_result    ()
  );

  // columns beyond the array are not tracked
  always_ff @(posedge i_clk) begin
    if (s0_ff.valid && 17'(s0_col_ff) < 17'(MAX_COLS)) begin
      col_mem[s0_col_ff[COL_W-1:0]] <= upd_st;
    end
  end

  // a zero pixel closes any open run before the result is taken
  llpe_col_unit u_fin (
    .i_pix       (16'h0000),
    .i_row       (16'h0000),
    .i_first_row (1'b0),
    .i_frac      (frac),
    .i_st        (col_mem[em_idx_ff[COL_W-1:0]]),
    .o_st        (fin_st),
    .o_result    (fin_result)
  );

  // ---------------- emission ----------------
  assign frame_done = s0_ff.valid & s0_ff.eof;
  assign em_last    = (em_idx_ff == width_ff - 16'h0001);
  assign comb_last  = !ctrl_ff[llpe_pkg::CTRL_COMB_BIT] ||
                      (comb_cnt_ff + 16'h0001 >= comb_lines_ff);

  // a frame that ends while the previous results still drain is not reported
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff  <= ST_IDLE;
      width_ff  <= 16'h0000;
      em_idx_ff <= 16'h0000;
      hi_ff     <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (frame_done) begin
            width_ff <= (17'(s0_col_ff) < 17'(MAX_COLS)) ? s0_col_ff + 16'h0001 : 16'(MAX_COLS);
            em_idx_ff <= 16'h0000;
            hi_ff     <= 1'b0;
            state_ff  <= (mode == llpe_pkg::MODE_PROF) ? ST_VID : ST_CHUNK;
          end
        end
        ST_VID: begin
          em_idx_ff <= em_idx_ff + 16'h0001;
          if (em_last) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_CHUNK: begin
          hi_ff <= ~hi_ff;
          if (hi_ff) begin
            em_idx_ff <= em_idx_ff + 16'h0001;
            if (em_last) begin
              state_ff <= ST_IDLE;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // the line count restarts with each packed frame
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      comb_cnt_ff <= 16'h0000;
    end else if (!ctrl_ff[llpe_pkg::CTRL_COMB_BIT]) begin
      comb_cnt_ff <= 16'h0000;
    end else if (state_ff == ST_VID && em_last) begin
      comb_cnt_ff <= comb_last ? 16'h0000 : comb_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      frame_cnt_ff <= 16'h0000;
    end else if (frame_done) begin
      frame_cnt_ff <= frame_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      vid_ff <= '0;
    end else if (mode != llpe_pkg::MODE_PROF) begin
      vid_ff <= src;
    end else if (state_ff == ST_VID) begin
      // profile is the only main stream
      vid_ff.valid <= 1'b1;
      vid_ff.sof   <= (em_idx_ff == 16'h0000) && (comb_cnt_ff == 16'h0000);
      vid_ff.eol   <= em_last;
      vid_ff.eof   <= em_last && comb_last;
      vid_ff.data  <= fin_result;
    end else begin
      vid_ff <= '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      chunk_ff <= '0;
    end else if (state_ff == ST_CHUNK) begin
      chunk_ff.valid <= 1'b1;
      chunk_ff.last  <= hi_ff && em_last;
      chunk_ff.data  <= hi_ff ? fin_result[15:8] : fin_result[7:0];
    end else begin
      chunk_ff <= '0;
    end
  end

  assign o_vid   = vid_ff;
  assign o_chunk = chunk_ff;

  // ---------------- assertions ----------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_lo_byte;
    o_chunk.valid && o_chunk.data == $past(fin_result[7:0]);
  endsequence
  sequence s_hi_byte;
    o_chunk.valid && o_chunk.data == $past(fin_result[15:8], 2);
  endsequence

  a_clamp_low: assert property (src.valid && src.data < lower |=> s0_ff.data == 16'h0000)
    else $error("pixel below lower clamp not zeroed");
  a_clamp_ceil: assert property (src.valid && src.data >= lower && src.data > ceil_ff
    |=> s0_ff.data == $past(ceil_ff))
    else $error("pixel above ceiling not saturated");
  a_split_second: assert property (src.valid && in_col >= split_ff && src.data < lo_second_ff
    |=> s0_ff.data == 16'h0000)
    else $error("second region lower clamp not applied");
  a_raw_pass: assert property (i_arst_n && mode == llpe_pkg::MODE_RAW
    |=> o_vid == $past(i_raw_pix)) else $error("mode 1 frame not raw");
  a_proc_pass: assert property (i_arst_n && mode == llpe_pkg::MODE_PROC
    |=> o_vid == $past(i_proc_pix)) else $error("mode 0 frame not processed");
  a_prof_only: assert property (mode == llpe_pkg::MODE_PROF && state_ff != ST_VID
    |=> !o_vid.valid)
    else $error("mode 2 emitted non-profile data");
  a_line_width: assert property (state_ff == ST_VID && em_last |=> o_vid.eol ##1 !o_vid.valid)
    else $error("profile line length wrong");
  a_chunk_order: assert property (state_ff == ST_CHUNK && !hi_ff |=> s_lo_byte ##1 s_hi_byte)
    else $error("chunk byte order wrong");
  a_comb_step: assert property (state_ff == ST_VID && em_last && !comb_last
    && ctrl_ff[llpe_pkg::CTRL_COMB_BIT] |=> comb_cnt_ff == $past(comb_cnt_ff) + 16'h0001
    && !o_vid.eof)
    else $error("combiner skipped a line");
  a_empty_zero: assert property (state_ff == ST_VID && fin_st.best_len == 16'h0000
    |=> o_vid.data == 16'h0000) else $error("empty column not zero");

endmodule : llpe_top

// ---- dv/llpe_pix_src.sv ----
// behavioural camera pipeline driving raster frames on both pixel streams
`timescale 1ns/10ps
module llpe_pix_src #(
  parameter int W = 4,
  parameter int H = 6
) (
  // control
  input  wire logic           i_clk,
  input  wire logic           i_go,
  // frame contents, row major
  input  wire logic [15:0]    i_proc [W*H],
  input  wire logic [15:0]    i_raw [W*H],
  // streams
  output llpe_pkg::llpe_pix_t o_proc,
  output llpe_pkg::llpe_pix_t o_raw,
  output logic                o_busy
);
  int n = 0;

  assign o_busy = i_go || (n != 0);

  initial begin
    o_proc = '0;
    o_raw = '0;
  end

  // every row has the same width; idle beats toggle data so nothing stale looks valid
  always @(posedge i_clk) begin
    if (o_busy) begin
      o_proc <= '{1'b1, n == 0, n % W == W - 1, n == W * H - 1, i_proc[n]};
      o_raw <= '{1'b1, n == 0, n % W == W - 1, n == W * H - 1, i_raw[n]};
      n <= (n == W * H - 1) ? 0 : n + 1;
    end else begin
      o_proc <= '{1'b0, 1'b0, 1'b0, 1'b0, ~o_proc.data};
      o_raw <= '{1'b0, 1'b0, 1'b0, 1'b0, ~o_raw.data};
    end
  end
endmodule : llpe_pix_src

// ---- dv/llpe_tb_top.sv ----
// self-checking bench: registers, profile modes, chunk bytes, frame combining
`timescale 1ns/10ps
module llpe_tb_top;
  localparam int          W = 4;
  localparam int          H = 6;
  localparam int          SPLIT = 2;
  localparam logic [15:0] LO1 = 16'h0010;
  localparam logic [15:0] LO2 = 16'h0020;
  localparam logic [15:0] CEIL = 16'h0100;

  logic                  i_clk;
  logic                  i_arst_n;
  logic                  i_hsel;
  logic                  i_hwrite;
  logic [1:0]            i_htrans;
  logic [2:0]            i_hsize;
  logic [31:0]           i_haddr;
  logic [31:0]           i_hwdata;
  logic [31:0]           o_hrdata;
  logic                  o_hreadyout;
  logic                  o_hresp;
  logic                  go;
  logic                  src_busy;
  llpe_pkg::llpe_pix_t   i_proc_pix;
  llpe_pkg::llpe_pix_t   i_raw_pix;
  llpe_pkg::llpe_pix_t   o_vid;
  llpe_pkg::llpe_chunk_t o_chunk;
  logic [15:0]           f_proc [W*H];
  logic [15:0]           f_raw [W*H];
  llpe_pkg::llpe_pix_t   q_vid [$];
  llpe_pkg::llpe_chunk_t q_chk [$];
  int                    n_errors = 0;
  int                    tests_run = 0;

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  llpe_top #(.MAX_COLS(W)) llpe_top_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .i_proc_pix(i_proc_pix), .i_raw_pix(i_raw_pix),
    .o_vid(o_vid), .o_chunk(o_chunk)
  );

  llpe_pix_src #(.W(W), .H(H)) llpe_pix_src_inst (
    .i_clk(i_clk), .i_go(go), .i_proc(f_proc), .i_raw(f_raw),
    .o_proc(i_proc_pix), .o_raw(i_raw_pix), .o_busy(src_busy)
  );

  always @(posedge i_clk) begin
    if (o_vid.valid === 1'b1) q_vid.push_back(o_vid);
    if (o_chunk.valid === 1'b1) q_chk.push_back(o_chunk);
  end

  task automatic test_done();
    $display("mismatches %0d, comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  task automatic timeout();
    $display("[FAIL] %0t wait ran out", $time);
    n_errors++;
    test_done();
  endtask : timeout

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // zero-wait slave, but the wait is still bounded rather than assumed
  task automatic hwait();
    int k;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_hreadyout !== 1'b1 && k < 50);
    if (o_hreadyout !== 1'b1) timeout();
  endtask : hwait

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_hwrite <= w;
    i_haddr <= {24'h000000, a};
    hwait();
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    hwait();
    rd = o_hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h00000000, r);
    chk(r, e, "register read");
    chk(o_hresp, 1'b0, "bus response");
  endtask : rdchk

  task automatic frame(input int nv, input int nc, input logic keep);
    int k;
    if (!keep) q_vid.delete();
    q_chk.delete();
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    k = 0;
    while ((q_vid.size() < nv || q_chk.size() < nc) && k < 500) begin
      @(posedge i_clk);
      k++;
    end
    if (q_vid.size() < nv || q_chk.size() < nc) timeout();
    // blanking so the next frame never meets a draining result line
    repeat (2 * W + 8) @(posedge i_clk);
  endtask : frame

  function automatic logic [15:0] exp_col(input int c, input logic raw, input int d);
    int s, l, bs, bl;
    logic [15:0] x, lo;
    s = 0;
    l = 0;
    bs = 0;
    bl = 0;
    lo = (c < SPLIT) ? LO1 : LO2;
    for (int r = 0; r < H; r++) begin
      x = raw ? f_raw[r*W+c] : f_proc[r*W+c];
      x = (x < lo) ? 16'h0000 : ((x > CEIL) ? CEIL : x);
      l = (x != 16'h0000) ? l + 1 : 0;
      if (l == 1) s = r;
      // strictly larger only, so equal runs leave the topmost in place
      if (l > bl) begin
        bl = l;
        bs = s;
      end
    end
    return (bl == 0) ? 16'h0000 : 16'((((2 * bs + bl - 1) << d) >> 1));
  endfunction : exp_col

  task automatic t_regs();
    rdchk(llpe_pkg::OFS_CTRL, llpe_pkg::CTRL_RST);
    rdchk(llpe_pkg::OFS_CEIL, {16'h0000, llpe_pkg::CEIL_RST});
    rdchk(llpe_pkg::OFS_COMB, {16'h0000, llpe_pkg::COMB_RST});
    rdchk(llpe_pkg::OFS_SPLIT, {16'h0000, llpe_pkg::SPLIT_RST});
    wr(8'h40, 32'hFFFFFFFF);
    rdchk(8'h40, 32'h00000000);
    wr(llpe_pkg::OFS_LOWER, {LO2, LO1});
    wr(llpe_pkg::OFS_CEIL, {16'h0000, CEIL});
    wr(llpe_pkg::OFS_SPLIT, SPLIT);
    rdchk(llpe_pkg::OFS_LOWER, {LO2, LO1});
  endtask : t_regs

  task automatic t_comb();
    wr(llpe_pkg::OFS_COMB, 32'h00000002);
    wr(llpe_pkg::OFS_CTRL, {24'h000000, 4'h4, 1'b1, 1'b0, llpe_pkg::MODE_PROF});
    frame(W, 0, 1'b0);
    frame(2 * W, 0, 1'b1);
    chk(q_vid.size(), 2 * W, "packed words"); // lines kept
    chk({q_vid[0].sof, q_vid[0].eof, q_vid[W-1].eof, q_vid[W].sof, q_vid[2*W-1].eof},
        5'b10001, "packed flags"); // two lines a frame
    for (int c = 0; c < 2 * W; c++) chk(q_vid[c].data, exp_col(c % W, 1'b0, 4), "packed");
    wr(llpe_pkg::OFS_COMB, 32'h00000001);
  endtask : t_comb

  task automatic t_prof(input logic raw, input int d);
    wr(llpe_pkg::OFS_CTRL, {24'h000000, 4'(d), 1'b0, raw, llpe_pkg::MODE_PROF});
    frame(W, 0, 1'b0);
    chk(q_vid.size(), W, "profile words"); // one word per column
    chk({q_vid[0].sof, q_vid[W-1].eol, q_vid[W-1].eof}, 3'b111, "line flags"); // one line
    for (int c = 0; c < W; c++) begin
      chk(q_vid[c].data, exp_col(c, raw, d), "profile");
    end
  endtask : t_prof

  task automatic t_chunk(input logic [1:0] m, input int d);
    logic raw;
    raw = (m == llpe_pkg::MODE_RAW);
    wr(llpe_pkg::OFS_CTRL, {24'h000000, 4'(d), 2'b00, m});
    frame(W * H, 2 * W, 1'b0);
    chk(q_vid.size(), W * H, "full frame"); // whole frame
    chk(q_vid[0].data, raw ? f_raw[0] : f_proc[0], "frame source");
    chk(q_chk.size(), 2 * W, "chunk bytes");
    for (int c = 0; c < W; c++) begin
      chk({q_chk[2*c+1].data, q_chk[2*c].data}, exp_col(c, raw, d), "chunk");
    end
    chk({q_chk[2*W-2].last, q_chk[2*W-1].last}, 2'b01, "chunk end"); // closing byte
  endtask : t_chunk

  initial begin
    i_arst_n = 1'b0;
    i_hsel = 1'b0;
    i_hwrite = 1'b0;
    i_htrans = 2'h0;
    i_hsize = 3'h2;
    i_haddr = 32'h00000000;
    i_hwdata = 32'h00000000;
    go = 1'b0;
    f_proc = '{16'h000F, 16'h0010, 16'h0030, 16'hFFFF,
               16'h000F, 16'h0000, 16'h001F, 16'hFFFF,
               16'h000F, 16'h0000, 16'h0020, 16'h0000,
               16'h000F, 16'h0020, 16'h0025, 16'h0000,
               16'h000F, 16'h0000, 16'h0040, 16'h0000,
               16'h000F, 16'h0000, 16'h0000, 16'h0000};
    for (int i = 0; i < W * H; i++) f_raw[i] = f_proc[(i + W) % (W * H)];
    repeat (16) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    t_regs();
    t_comb();
    t_prof(1'b0, 4);
    t_prof(1'b1, 1);
    t_chunk(llpe_pkg::MODE_PROC, 4);
    t_chunk(llpe_pkg::MODE_RAW, 4);
    t_chunk(2'h3, 2);
    // seven frames ended, emission idle; status is read-only
    wr(llpe_pkg::OFS_STATUS, 32'hFFFFFFFF);
    rdchk(llpe_pkg::OFS_STATUS, 32'h0007_0000);
    test_done();
  end
endmodule : llpe_tb_top
